// ==== rtl/qsw_pkg.sv ====
// constants, field layout and helper functions of the scan word formatter
package qsw_pkg;

  localparam int ADC_W = 12;
  localparam int WORD_W = 16;
  localparam int CH_N = 4;
  localparam int CODE_W = 2;
  localparam int SAMP_LSB = 0;
  localparam int CODE_LSB = 12;
  localparam int BUSY_BIT = 14;
  localparam int SIGN_BIT = 15;
  localparam logic [ADC_W-1:0] SAMP_FULL = 12'hfff;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [CODE_W-1:0] CH_RST = 2'h0;

  localparam int CLK_PERIOD_NS = 10;
  // conversion start interval per channel
  localparam int CONV_US = 10;
  localparam int CONV_CYC = CONV_US * 1000 / CLK_PERIOD_NS;
  localparam int CONV_CW = 10;
  // step response time, in tenths of a millisecond (8.2 ms)
  localparam int SETTLE_TENTH_MS = 82;
  localparam int SETTLE_CYC_DEF = SETTLE_TENTH_MS * 100000 / CLK_PERIOD_NS;
  localparam int SETTLE_CW = 20;

  // next channel in the rotation; last is the highest enabled channel
  function automatic logic [CODE_W-1:0] qsw_next_ch(
    input logic [CODE_W-1:0] cur,
    input logic [CODE_W-1:0] last
  );
    return (cur >= last) ? CH_RST : cur + 2'h1;
  endfunction

  // assemble one presented word from a stored channel result
  function automatic logic [WORD_W-1:0] qsw_word(
    input logic [ADC_W-1:0] samp,
    input logic neg,
    input logic flt,
    input logic bip,
    input logic busy,
    input logic [CODE_W-1:0] code
  );
    logic [WORD_W-1:0] w;
    w = WORD_RST;
    w[SAMP_LSB +: ADC_W] = flt ? '0 : samp;
    w[CODE_LSB +: CODE_W] = code;
    w[BUSY_BIT] = busy;
    w[SIGN_BIT] = flt | (bip & neg);
    return w;
  endfunction

endpackage

// ==== rtl/qsw_if.sv ====
// carrier between the conversion sequencer and the word formatter
`timescale 1ns/10ps
interface qsw_if;
  import qsw_pkg::*;
  logic [ADC_W-1:0] samp [CH_N];
  logic neg [CH_N];
  logic flt [CH_N];
  logic res_tick;
  logic [CODE_W-1:0] last;

  modport conv (output samp, neg, flt, res_tick, input last);
  modport fmt (input samp, neg, flt, res_tick, output last);
  modport mon (input res_tick);
endinterface

// ==== rtl/qsw_conv.sv ====
// free-running conversion sequencer over the enabled channels
`timescale 1ns/10ps
module qsw_conv import qsw_pkg::*; (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  qsw_if.conv cif, // stored results toward formatter
  input wire logic [ADC_W-1:0] adc_data, // converter result
  input wire logic adc_neg, // converter input below zero
  input wire logic adc_ready, // converter result strobe
  input wire logic [CH_N-1:0] ch_fault, // per-channel failure level
  output logic adc_start, // start one conversion
  output logic [CODE_W-1:0] adc_chan // channel being converted
);
  typedef enum logic [0:0] {CV_IDLE, CV_WAIT} qsw_cv_t;

  qsw_cv_t st_q;
  logic [CONV_CW-1:0] cnt_q;
  logic [CODE_W-1:0] ch_q;
  logic [ADC_W-1:0] mem_q [CH_N];
  logic neg_q [CH_N];
  logic flt_q [CH_N];
  logic tick_q;
  wire tick = (cnt_q == CONV_CW'(CONV_CYC - 1));

  assign cif.samp = mem_q;
  assign cif.neg = neg_q;
  assign cif.flt = flt_q;
  assign cif.res_tick = tick_q;

  // paced by its own divider, never by the host scan
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= tick ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= CV_IDLE;
      ch_q <= CH_RST;
      adc_start <= 1'b0;
      adc_chan <= CH_RST;
      tick_q <= 1'b0;
      for (int i = 0; i < CH_N; i++) begin
        mem_q[i] <= '0;
        neg_q[i] <= 1'b0;
        flt_q[i] <= 1'b0;
      end
    end else begin
      adc_start <= 1'b0;
      tick_q <= 1'b0;
      unique case (st_q)
        CV_IDLE: if (tick) begin
          adc_start <= 1'b1;
          adc_chan <= (ch_q > cif.last) ? CH_RST : ch_q;
          ch_q <= (ch_q > cif.last) ? CH_RST : ch_q;
          st_q <= CV_WAIT;
        end
        CV_WAIT: if (adc_ready) begin
          mem_q[ch_q] <= adc_data;
          neg_q[ch_q] <= adc_neg;
          flt_q[ch_q] <= ch_fault[ch_q];
          tick_q <= 1'b1;
          ch_q <= qsw_next_ch(ch_q, cif.last);
          st_q <= CV_IDLE;
        end
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_req;
    st_q == CV_IDLE && tick;
  endsequence

  a_conv_start: assert property (s_req |=> adc_start ##1 !adc_start)
    else $error("conversion start not a single pulse");
  a_conv_store: assert property (st_q == CV_WAIT && adc_ready |=>
    cif.res_tick && mem_q[$past(ch_q)] == $past(adc_data))
    else $error("conversion result not stored");
endmodule

// ==== rtl/qsw_watch.sv ====
// flags results older than the step response time as disturbed
`timescale 1ns/10ps
module qsw_watch import qsw_pkg::*; #(
  parameter int SETTLE_CYC = SETTLE_CYC_DEF // settle bound in cycles
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  qsw_if.mon cif, // result tick from sequencer
  output logic stale // no fresh result within bound
);
  logic [SETTLE_CW-1:0] cnt_q;
  wire at_lim = (cnt_q >= SETTLE_CW'(SETTLE_CYC));

  // a stalled converter cannot honour the step response time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (cif.res_tick) begin
      cnt_q <= '0;
    end else if (!at_lim) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign stale = at_lim;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_stale_clear: assert property (cif.res_tick |=> !stale)
    else $error("stale flag survives a fresh result");
endmodule

// ==== rtl/qsw_top.sv ====
// four-channel converter control presenting one 16-bit word per scan
`timescale 1ns/10ps
module qsw_top import qsw_pkg::*; #(
  parameter int SETTLE_CYC = SETTLE_CYC_DEF // step response bound
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic nrst, // async reset, active low
  input wire logic scan_strobe, // host scan boundary pulse
  input wire logic ptr_mode, // 1: all channels per scan
  input wire logic [1:0] ch_count_sel, // enabled channel count select
  input wire logic bipolar, // bipolar input range selected
  input wire logic noise_hit, // conversion disturbed by noise
  input wire logic [ADC_W-1:0] adc_data, // converter result
  input wire logic adc_neg, // converter input below zero
  input wire logic adc_ready, // converter result strobe
  input wire logic [CH_N-1:0] ch_fault, // per-channel failure level
  output logic adc_start, // start one conversion
  output logic [CODE_W-1:0] adc_chan, // channel being converted
  output logic [WORD_W-1:0] in_word, // presented input word
  output logic [CH_N*WORD_W-1:0] ptr_words, // all channels, pointer mode
  output logic word_upd // word refreshed this cycle
);
  ////////////////////////////////////////////////////////////////////////
  // conversion side

  qsw_if cif ();
  logic stale;

  qsw_conv u_conv (
    .clk(clk),
    .nrst(nrst),
    .cif(cif.conv),
    .adc_data(adc_data),
    .adc_neg(adc_neg),
    .adc_ready(adc_ready),
    .ch_fault(ch_fault),
    .adc_start(adc_start),
    .adc_chan(adc_chan)
  );

  qsw_watch #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_watch (
    .clk(clk),
    .nrst(nrst),
    .cif(cif.mon),
    .stale(stale)
  );

  ////////////////////////////////////////////////////////////////////////
  // channel selection

  logic [CODE_W-1:0] cur_q;
  logic first_q;
  logic noise_q;
  logic [WORD_W-1:0] word_q;
  logic [CH_N*WORD_W-1:0] ptr_q;
  logic upd_q;

  // select code equals the highest enabled channel index
  wire [CODE_W-1:0] last_ch = ch_count_sel;
  assign cif.last = last_ch;

  // a shrunk selection drops the pointer back onto channel one
  wire [CODE_W-1:0] cur_eff = (cur_q > last_ch) ? CH_RST : cur_q;
  wire [CODE_W-1:0] cur_nxt = qsw_next_ch(cur_eff, last_ch);

  // first scan always busy; later only on disturbance
  wire busy_w = first_q | noise_q | noise_hit | stale;

  ////////////////////////////////////////////////////////////////////////
  // word assembly

  wire cur_flt = cif.flt[cur_eff];
  wire [WORD_W-1:0] mux_word = qsw_word(cif.samp[cur_eff],
    cif.neg[cur_eff], cur_flt, bipolar, busy_w, cur_eff);

  logic [WORD_W-1:0] pw [CH_N];
  logic [CH_N*WORD_W-1:0] ptr_flat;

  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi++) begin : g_ptr
      // disabled channels present an all-zero word
      assign pw[gi] = (CODE_W'(gi) <= last_ch) ?
        qsw_word(cif.samp[gi], cif.neg[gi], cif.flt[gi], bipolar,
                 busy_w, CODE_W'(gi)) : WORD_RST;
      assign ptr_flat[gi*WORD_W +: WORD_W] = pw[gi];
    end
  endgenerate

  // in pointer mode the single word shows the last enabled channel
  wire [WORD_W-1:0] word_d = ptr_mode ? pw[last_ch] : mux_word;

  ////////////////////////////////////////////////////////////////////////
  // scan-aligned registers

  // every field is captured in one edge, no mixed channels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_q <= WORD_RST;
      ptr_q <= '0;
    end else if (scan_strobe) begin
      word_q <= word_d;
      if (ptr_mode) begin
        ptr_q <= ptr_flat;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur_q <= CH_RST;
      first_q <= 1'b1;
    end else if (scan_strobe) begin
      cur_q <= ptr_mode ? cur_eff : cur_nxt;
      first_q <= 1'b0;
    end
  end

  // sticky until the next scan takes it; a new hit beats the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      noise_q <= 1'b0;
    end else begin
      noise_q <= noise_hit | (noise_q & !scan_strobe);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= scan_strobe;
    end
  end

  assign in_word = word_q;
  assign ptr_words = ptr_q;
  assign word_upd = upd_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_mux_scan;
    scan_strobe && !ptr_mode;
  endsequence

  sequence s_ptr_scan;
    scan_strobe && ptr_mode;
  endsequence

  a_word_stable: assert property (!scan_strobe |=> $stable(in_word))
    else $error("word changed outside a scan boundary");

  a_update_pulse: assert property (scan_strobe |=> word_upd)
    else $error("scan did not refresh the word");

  a_no_extra_upd: assert property (!scan_strobe |=> !word_upd)
    else $error("word refresh without a scan");

  a_sample_bits: assert property (s_mux_scan and !cur_flt |=>
    in_word[ADC_W-1:0] == $past(cif.samp[cur_eff]))
    else $error("sample bits differ from stored result");

  a_chan_code: assert property (s_mux_scan |=>
    in_word[CODE_LSB +: CODE_W] == $past(cur_eff))
    else $error("channel code differs from presented channel");

  a_rot_wrap: assert property (s_mux_scan and cur_eff == last_ch |=>
    cur_q == CH_RST)
    else $error("rotation did not wrap to channel one");

  a_rot_skip: assert property (s_mux_scan and cur_eff < last_ch |=>
    cur_q == $past(cur_eff) + 2'h1 && cur_q <= $past(last_ch))
    else $error("rotation skipped an enabled channel");

  a_busy_first: assert property (scan_strobe && first_q |=>
    in_word[BUSY_BIT] ##1 !first_q)
    else $error("first scan word not busy");

  a_busy_quiet: assert property (scan_strobe && !first_q && !noise_q &&
    !noise_hit && !stale |=> !in_word[BUSY_BIT])
    else $error("busy set without disturbance");

  a_fault_zero: assert property (s_mux_scan and cur_flt |=>
    in_word[SIGN_BIT] && in_word[ADC_W-1:0] == '0)
    else $error("failed channel not flagged with zero sample");

  a_sign_neg: assert property (s_mux_scan and bipolar &&
    cif.neg[cur_eff] |=> in_word[SIGN_BIT])
    else $error("negative bipolar input without sign");

  a_unipolar_pos: assert property (s_mux_scan and !bipolar && !cur_flt
    |=> !in_word[SIGN_BIT])
    else $error("sign set in unipolar range");

  a_ptr_all: assert property (s_ptr_scan and last_ch == 2'h3 |=>
    ptr_words[3*WORD_W + CODE_LSB +: CODE_W] == 2'h3 &&
    ptr_words[CODE_LSB +: CODE_W] == 2'h0)
    else $error("pointer scan missing a channel word");

  a_ptr_last: assert property (s_ptr_scan |=>
    in_word[CODE_LSB +: CODE_W] == $past(last_ch))
    else $error("pointer word not from last channel");

endmodule

// ==== verif/qsw_adc_model.sv ====
// behavioural converter answering start pulses with random results
`timescale 1ns/10ps
module qsw_adc_model import qsw_pkg::*; (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic adc_start, // conversion request
  input wire logic mute, // hold the answer back
  output logic [ADC_W-1:0] adc_data, // result word
  output logic adc_neg, // result below zero
  output logic adc_ready, // result strobe
  output logic calm // no conversion near
);
  logic pend_q = 1'b0;
  int cnt_q = 0;
  int since_q = 9;
  assign calm = !pend_q && since_q >= 4;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      adc_ready <= 1'b0;
      adc_data <= 12'h000;
      adc_neg <= 1'b0;
    end else begin
      adc_ready <= 1'b0;
      // outside the strobe the lines toggle, so a late sample shows up
      adc_data <= ~adc_data;
      adc_neg <= ~adc_neg;
      since_q <= since_q + 1;
      if (adc_start) begin
        pend_q <= 1'b1;
        cnt_q <= 2 + $urandom_range(18);
      end else if (pend_q && !mute) begin
        if (cnt_q <= 1) begin
          adc_ready <= 1'b1;
          adc_data <= 12'($urandom);
          adc_neg <= 1'($urandom);
          pend_q <= 1'b0;
          since_q <= 0;
        end else begin
          cnt_q <= cnt_q - 1;
        end
      end
    end
  end
endmodule

// ==== verif/quad_adc_scan_word_formatter_tb.sv ====
// self-checking bench for the scan word formatter
`timescale 1ns/10ps
module quad_adc_scan_word_formatter_tb;
  import qsw_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scan_strobe = 1'b0;
  logic ptr_mode = 1'b0;
  logic bipolar = 1'b0;
  logic noise_hit = 1'b0;
  logic mute = 1'b0;
  logic [1:0] ch_count_sel = 2'h3;
  logic [CH_N-1:0] ch_fault = 4'h0;
  logic [ADC_W-1:0] adc_data;
  logic adc_neg, adc_ready, adc_start, word_upd, calm;
  logic [CODE_W-1:0] adc_chan;
  logic [WORD_W-1:0] in_word;
  logic [CH_N*WORD_W-1:0] ptr_words;
  int error_cnt = 0;
  int samples_checked = 0;
  int m_samp [CH_N];
  bit m_neg [CH_N];
  bit m_flt [CH_N];
  int cur;
  bit first, noise_st, force_busy;
  logic [63:0] exp_ptr;
  // conversion rotation as the sequencer should walk it
  int cv = 0;
  int low_cnt = 0;
  logic [1:0] sel_d = 2'h3;
  // host threshold for a broken 4-20 mA loop on the 0-5 V range
  localparam logic [11:0] BROKEN_LIM = 12'h2ee;
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  // settle bound kept above two conversion intervals to avoid false busy
  qsw_top #(.SETTLE_CYC(3000)) uut (.clk(clk), .nrst(nrst),
    .scan_strobe(scan_strobe), .ptr_mode(ptr_mode),
    .ch_count_sel(ch_count_sel), .bipolar(bipolar), .noise_hit(noise_hit),
    .adc_data(adc_data), .adc_neg(adc_neg), .adc_ready(adc_ready),
    .ch_fault(ch_fault), .adc_start(adc_start), .adc_chan(adc_chan),
    .in_word(in_word), .ptr_words(ptr_words), .word_upd(word_upd));
  qsw_adc_model adc (.clk(clk), .nrst(nrst), .adc_start(adc_start),
    .mute(mute), .adc_data(adc_data), .adc_neg(adc_neg),
    .adc_ready(adc_ready), .calm(calm));
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    // the sequencer picks its channel one edge before the start shows
    sel_d <= ch_count_sel;
    if (nrst && adc_start) begin
      if (cv > sel_d) cv = 0;
      chk(adc_chan, 64'(cv));
    end
    if (nrst && adc_ready) begin
      m_samp[adc_chan] = adc_data;
      m_neg[adc_chan] = adc_neg;
      m_flt[adc_chan] = ch_fault[adc_chan];
      cv = (adc_chan >= ch_count_sel) ? 0 : adc_chan + 1;
    end
  end
  function automatic logic [15:0] word(int c, bit busy);
    logic [15:0] w;
    w[11:0] = m_flt[c] ? 12'h000 : 12'(m_samp[c]);
    w[13:12] = 2'(c);
    w[14] = busy;
    w[15] = m_flt[c] | (bipolar & m_neg[c]);
    return w;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict();
    $display("checks %0d errors %0d low readings %0d", samples_checked,
      error_cnt, low_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task do_reset();
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < CH_N; i++) begin
      m_samp[i] = 0;
      m_neg[i] = 0;
      m_flt[i] = 0;
    end
    cur = 0;
    cv = 0;
    first = 1;
    noise_st = 0;
    exp_ptr = '0;
    chk(in_word, 64'h0);
    nrst <= 1'b1;
  endtask
  task scan(input bit wait_calm);
    logic [15:0] exp_w;
    int last;
    int ch;
    bit busy;
    do begin
      @(posedge clk);
      #1;
    end while (wait_calm && !calm);
    @(posedge clk);
    scan_strobe <= 1'b1;
    @(posedge clk);
    scan_strobe <= 1'b0;
    last = ch_count_sel;
    busy = first | noise_st | force_busy;
    first = 0;
    noise_st = 0;
    // pointer scans hold the rotation but still fold it back onto ch1
    if (cur > last) cur = 0;
    if (ptr_mode) begin
      for (int i = 0; i < CH_N; i++)
        exp_ptr[16*i +: 16] = (i <= last) ? word(i, busy) : 16'h0000;
      exp_w = word(last, busy);
      ch = last;
    end else begin
      exp_w = word(cur, busy);
      ch = cur;
      cur = (cur >= last) ? 0 : cur + 1;
    end
    #1;
    chk(word_upd, 64'h1);
    chk(in_word, exp_w);
    chk(ptr_words, exp_ptr);
    // a nonzero sample means the top bit can only be the sign
    if (in_word[11:0] != 12'h000) begin
      chk(in_word[15], 64'(bipolar & m_neg[ch]));
    end
    // host side watch for a broken current loop transmitter
    if (!in_word[15] && in_word[11:0] < BROKEN_LIM) begin
      low_cnt++;
    end
    @(posedge clk);
    #1;
    chk(word_upd, 64'h0);
  endtask
  task pause();
    repeat ($urandom_range(1500, 10)) @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(61371));
    force_busy = 0;
    do_reset();
    repeat (4500) @(posedge clk);
    scan(1);
    for (int s = 0; s < 4; s++) begin
      ch_count_sel <= 2'(s);
      repeat (6) begin
        bipolar <= 1'($urandom);
        ch_fault <= 4'($urandom);
        pause();
        scan(1);
      end
    end
    ptr_mode <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      ch_count_sel <= 2'(s);
      pause();
      scan(1);
    end
    ptr_mode <= 1'b0;
    @(posedge clk);
    noise_hit <= 1'b1;
    noise_st = 1;
    @(posedge clk);
    noise_hit <= 1'b0;
    scan(1);
    scan(1);
    mute <= 1'b1;
    repeat (3500) @(posedge clk);
    force_busy = 1;
    scan(0);
    mute <= 1'b0;
    force_busy = 0;
    repeat (1500) @(posedge clk);
    scan(1);
    @(posedge clk);
    do_reset();
    repeat (4500) @(posedge clk);
    scan(1);
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
